//--- core/sap_pkg.sv
// Shared constants, types and helpers for the stereo serial audio port
package sap_pkg;

    // Register byte offsets
    localparam logic [4:0] SAP_OFS_CTRL      = 5'h00;
    localparam logic [4:0] SAP_OFS_STATUS    = 5'h04;
    localparam logic [4:0] SAP_OFS_PB_LEFT   = 5'h08;
    localparam logic [4:0] SAP_OFS_PB_RIGHT  = 5'h0C;
    localparam logic [4:0] SAP_OFS_REC_LEFT  = 5'h10;
    localparam logic [4:0] SAP_OFS_REC_RIGHT = 5'h14;

    // Control register field positions
    localparam int SAP_CTRL_PB_MASTER  = 0;
    localparam int SAP_CTRL_REC_MASTER = 1;
    localparam int SAP_CTRL_PB_INV     = 2;
    localparam int SAP_CTRL_REC_INV    = 3;
    localparam int SAP_CTRL_PB_FMT     = 4;
    localparam int SAP_CTRL_PB_POL     = 6;
    localparam int SAP_CTRL_PB_WL      = 8;
    localparam int SAP_CTRL_REC_FMT    = 10;
    localparam int SAP_CTRL_REC_POL    = 12;
    localparam int SAP_CTRL_REC_WL     = 13;
    localparam int SAP_CTRL_ZMUTE_EN   = 15;
    localparam int SAP_CTRL_DEEMPH     = 16;
    localparam logic [31:0] SAP_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SAP_CTRL_MASK  = 32'h0001_FFFF;

    typedef enum logic [1:0] {
        SAP_FMT_RJ  = 2'b00,
        SAP_FMT_LJ  = 2'b01,
        SAP_FMT_I2S = 2'b10,
        SAP_FMT_DSP = 2'b11
    } sap_fmt_t;

    // Word length codes
    localparam logic [1:0] SAP_WL16 = 2'b00;
    localparam logic [1:0] SAP_WL20 = 2'b01;
    localparam logic [1:0] SAP_WL24 = 2'b10;
    localparam logic [1:0] SAP_WL32 = 2'b11;

    // Timing of generated clocks in master mode
    localparam int CLK_MHZ         = 200;
    localparam int BCLK_HALF_NS    = 40;
    localparam int BCLK_HALF_CYC   = (BCLK_HALF_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] FRAME_HALF_BITS = 8'h20;
    localparam logic [7:0] DSP_FRAME_BITS  = 8'hC0;
    localparam logic [10:0] ZERO_RUN       = 11'h400;

    function automatic logic [5:0] sap_wl_bits(input logic [1:0] code, input sap_fmt_t fmt);
        case (code)
            SAP_WL16: sap_wl_bits = 6'h10;
            SAP_WL20: sap_wl_bits = 6'h14;
            SAP_WL24: sap_wl_bits = 6'h18;
            default:  sap_wl_bits = (fmt == SAP_FMT_RJ) ? 6'h18 : 6'h20;
        endcase
    endfunction

    function automatic logic [31:0] sap_mask(input logic [31:0] w, input logic [5:0] wl);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            m[i] = (6'(i) < wl) ? w[i] : 1'b0;
        end
        return m;
    endfunction

    function automatic logic sap_bit(input logic [31:0] w, input logic [8:0] n);
        return w[n[4:0]];
    endfunction

endpackage

//--- core/sap_edge_if.sv
// Bit clock events and frame level passed from a clock front end to the port logic
`timescale 1ns/1ps
`default_nettype none
interface sap_edge_if;
    logic take;
    logic launch;
    logic frame;
    modport src (output take, output launch, output frame);
    modport dst (input take, input launch, input frame);
endinterface
`default_nettype wire

//--- core/sap_link_clk.sv
// Bit/frame clock front end: slave edge finder or master clock generator
`timescale 1ns/1ps
`default_nettype none
module sap_link_clk
    import sap_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  master,
    input  wire logic  invert,
    input  wire logic  dsp,
    input  wire logic  bclk_i,
    input  wire logic  lrc_i,
    output logic       bclk_o,
    output logic       bclk_oe,
    output logic       lrc_o,
    output logic       lrc_oe,
    sap_edge_if.src    ev
);
    localparam logic [3:0] DIV_LAST = 4'(BCLK_HALF_CYC - 1);

    logic       b_s1_q, b_s2_q, l_s1_q, l_s2_q;
    logic       eff_prev_q;
    logic [3:0] div_q;
    logic       gen_bclk_q, gen_lrc_q;
    logic [7:0] bit_q;
    logic       take_q, launch_q;
    logic       eff, tick, m_rise, m_fall;
    logic [7:0] bit_last, bit_n;

    always_ff @(posedge clock) begin
        if (rst) begin
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            l_s1_q <= 1'b0;
            l_s2_q <= 1'b0;
        end else begin
            b_s1_q <= bclk_i;
            b_s2_q <= b_s1_q;
            l_s1_q <= lrc_i;
            l_s2_q <= l_s1_q;
        end
    end

    assign eff      = b_s2_q ^ invert;
    assign tick     = (div_q == DIV_LAST);
    assign m_rise   = tick & ~gen_bclk_q;
    assign m_fall   = tick & gen_bclk_q;
    assign bit_last = dsp ? (DSP_FRAME_BITS - 8'h01) : ((FRAME_HALF_BITS << 1) - 8'h01);
    assign bit_n    = (bit_q >= bit_last) ? 8'h00 : bit_q + 8'h01;

    // Master clock generation; frame level moves with the bit clock fall
    always_ff @(posedge clock) begin
        if (rst || !master) begin
            div_q      <= 4'h0;
            gen_bclk_q <= 1'b0;
            gen_lrc_q  <= 1'b0;
            bit_q      <= 8'h00;
        end else begin
            div_q <= tick ? 4'h0 : div_q + 4'h1;
            if (tick) begin
                gen_bclk_q <= ~gen_bclk_q;
            end
            if (m_fall) begin
                bit_q     <= bit_n;
                gen_lrc_q <= dsp ? (bit_n == 8'h00) : (bit_n < FRAME_HALF_BITS);
            end
        end
    end

    // Launch lags one cycle so a frame edge near the bit clock fall is already seen
    always_ff @(posedge clock) begin
        if (rst) begin
            eff_prev_q <= 1'b0;
            take_q     <= 1'b0;
            launch_q   <= 1'b0;
        end else begin
            eff_prev_q <= eff;
            take_q     <= master ? m_rise : (eff & ~eff_prev_q);
            launch_q   <= master ? m_fall : (~eff & eff_prev_q);
        end
    end

    assign ev.take   = take_q;
    assign ev.launch = launch_q;
    assign ev.frame  = master ? gen_lrc_q : l_s2_q;
    assign bclk_o    = gen_bclk_q ^ invert;
    assign lrc_o     = gen_lrc_q;
    assign bclk_oe   = master;
    assign lrc_oe    = master;
endmodule // sap_link_clk
`default_nettype wire

//--- core/sap_audio_port.sv
// Stereo codec serial audio port: playback receiver, record sender, zero detect
//
// Overview of operation
// - Hardware mode pins pick 24 RJ, 20 RJ, 16 I2S or 24 I2S for both halves.
// - Hardware mode de-emphasis pin: low off, high on.
// - Each half picks master or slave, defaulting to slave; data pins never turn.
// - Slave mode takes input data and playback frame clock on the rising bit clock.
// - Record data changes on the falling bit clock unless inverted.
// - Invert bits move playback sampling to falling and record launch to rising.
// - Master mode drives the bit clock and frame clock of its own half.
// - All formats MSB first, 16/20/24/32 bits; no 32-bit right justified.
// - Left justified MSB at first edge after frame change; high is left.
// - Right justified LSB at edge just before frame change; high is left.
// - I2S MSB at second rising edge, first falling edge; low is left.
// - DSP A playback MSB at second rising edge after frame rise, right follows.
// - DSP A record MSB at first falling edge after frame rise, right follows.
// - DSP B playback MSB at first rising edge after frame rise.
// - DSP B record MSB on the falling edge of the frame rise, right follows.
// - Each channel flags 1024 zero samples; optional automatic playback mute.
// - Playback format field: 00 RJ, 01 LJ, 10 I2S, 11 DSP.
// - Frame polarity bit inverts frame sense, or picks DSP A (0) or B (1).
// - Hardware control mode forces both halves to clock slave.
`timescale 1ns/1ps
`default_nettype none
module sap_audio_port
    import sap_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        hw_mode_pin,
    input  wire logic        format_select_pin,
    input  wire logic        wordlen_select_pin,
    input  wire logic        deemph_select_pin,
    input  wire logic        playback_bit_clock_i,
    output logic             playback_bit_clock_o,
    output logic             playback_bit_clock_oe,
    input  wire logic        playback_frame_clock_i,
    output logic             playback_frame_clock_o,
    output logic             playback_frame_clock_oe,
    input  wire logic        playback_serial_in,
    input  wire logic        record_bit_clock_i,
    output logic             record_bit_clock_o,
    output logic             record_bit_clock_oe,
    input  wire logic        record_frame_clock_i,
    output logic             record_frame_clock_o,
    output logic             record_frame_clock_oe,
    output logic             record_serial_out,
    output logic             deemph_enable,
    output logic             zero_detect_mute,
    output logic             playback_mute_left,
    output logic             playback_mute_right
);
    sap_edge_if pb_ev ();
    sap_edge_if rc_ev ();

    logic [3:0]  pin_s1_q, pin_s2_q;
    logic        din_s1_q, din_s2_q;
    logic [31:0] ctrl_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] pb_word_q [2];
    logic [31:0] rec_word_q [2];
    logic [10:0] zc_q [2];
    logic        pb_prev_q, rc_prev_q;
    logic [7:0]  pb_cnt_q, rc_cnt_q;
    logic [8:0]  rc_len_q;
    logic [31:0] pb_col_q;
    logic        rc_out_q;

    logic        hw, hw_deemph;
    sap_fmt_t    pb_fmt, rc_fmt, hw_fmt;
    logic [5:0]  pb_wl, rc_wl;
    logic [1:0]  hw_wl;
    logic        pb_pol, rc_pol, pb_master, rc_master;
    logic        zero_l, zero_r;

    // Pins from outside the clock domain
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= {hw_mode_pin, format_select_pin, wordlen_select_pin, deemph_select_pin};
            pin_s2_q <= pin_s1_q;
            din_s1_q <= playback_serial_in;
            din_s2_q <= din_s1_q;
        end
    end

    assign hw        = pin_s2_q[3];
    assign hw_deemph = pin_s2_q[0];

    // Hardware mode decoding of format and word length
    always_comb begin
        case (pin_s2_q[2:1])
            2'b00:   begin hw_fmt = SAP_FMT_RJ;  hw_wl = SAP_WL24; end
            2'b01:   begin hw_fmt = SAP_FMT_RJ;  hw_wl = SAP_WL20; end
            2'b10:   begin hw_fmt = SAP_FMT_I2S; hw_wl = SAP_WL16; end
            default: begin hw_fmt = SAP_FMT_I2S; hw_wl = SAP_WL24; end
        endcase
    end

    always_comb begin
        pb_fmt    = hw ? hw_fmt : sap_fmt_t'(ctrl_q[SAP_CTRL_PB_FMT +: 2]);
        rc_fmt    = hw ? hw_fmt : sap_fmt_t'(ctrl_q[SAP_CTRL_REC_FMT +: 2]);
        pb_wl     = sap_wl_bits(hw ? hw_wl : ctrl_q[SAP_CTRL_PB_WL +: 2], pb_fmt);
        rc_wl     = sap_wl_bits(hw ? hw_wl : ctrl_q[SAP_CTRL_REC_WL +: 2], rc_fmt);
        pb_pol    = ~hw & ctrl_q[SAP_CTRL_PB_POL];
        rc_pol    = ~hw & ctrl_q[SAP_CTRL_REC_POL];
        pb_master = ~hw & ctrl_q[SAP_CTRL_PB_MASTER];
        rc_master = ~hw & ctrl_q[SAP_CTRL_REC_MASTER];
    end

    assign deemph_enable = hw ? hw_deemph : ctrl_q[SAP_CTRL_DEEMPH];

    // Separate front ends keep the two halves free of any phase relation
    sap_link_clk u_pb_clk (
        .clock   (clock),
        .rst     (rst),
        .master  (pb_master),
        .invert  (~hw & ctrl_q[SAP_CTRL_PB_INV]),
        .dsp     (pb_fmt == SAP_FMT_DSP),
        .bclk_i  (playback_bit_clock_i),
        .lrc_i   (playback_frame_clock_i),
        .bclk_o  (playback_bit_clock_o),
        .bclk_oe (playback_bit_clock_oe),
        .lrc_o   (playback_frame_clock_o),
        .lrc_oe  (playback_frame_clock_oe),
        .ev      (pb_ev.src)
    );

    sap_link_clk u_rc_clk (
        .clock   (clock),
        .rst     (rst),
        .master  (rc_master),
        .invert  (~hw & ctrl_q[SAP_CTRL_REC_INV]),
        .dsp     (rc_fmt == SAP_FMT_DSP),
        .bclk_i  (record_bit_clock_i),
        .lrc_i   (record_frame_clock_i),
        .bclk_o  (record_bit_clock_o),
        .bclk_oe (record_bit_clock_oe),
        .lrc_o   (record_frame_clock_o),
        .lrc_oe  (record_frame_clock_oe),
        .ev      (rc_ev.src)
    );

    // Playback receiver, evaluated at each sampling edge
    logic        pb_lrc, pb_start, pb_left, pb_dsp;
    logic [7:0]  pb_idx;
    logic [8:0]  pb_off, pb_end1, pb_end2;
    logic [31:0] pb_shift, pb_word;
    logic [1:0]  pb_we;

    always_comb begin
        pb_lrc   = pb_ev.frame;
        pb_dsp   = (pb_fmt == SAP_FMT_DSP);
        pb_start = pb_dsp ? (pb_lrc & ~pb_prev_q) : (pb_lrc ^ pb_prev_q);
        pb_idx   = pb_start ? 8'h00 : ((pb_cnt_q == 8'hFF) ? pb_cnt_q : pb_cnt_q + 8'h01);
        case (pb_fmt)
            SAP_FMT_LJ:  pb_off = 9'h000;
            SAP_FMT_I2S: pb_off = 9'h001;
            SAP_FMT_DSP: pb_off = pb_pol ? 9'h000 : 9'h001;
            default:     pb_off = 9'h000;
        endcase
        pb_end1  = pb_off + {3'b000, pb_wl} - 9'h001;
        pb_end2  = pb_end1 + {3'b000, pb_wl};
        pb_shift = {pb_col_q[30:0], din_s2_q};
        // I2S reverses the level that marks the left word
        pb_left  = (pb_lrc ^ pb_pol) ^ (pb_fmt == SAP_FMT_I2S);
        pb_word  = 32'h0000_0000;
        pb_we    = 2'b00;
        if (pb_fmt == SAP_FMT_RJ) begin
            if (pb_lrc ^ pb_prev_q) begin
                pb_word = sap_mask(pb_col_q, pb_wl);
                pb_we   = (pb_prev_q ^ pb_pol) ? 2'b01 : 2'b10;
            end
        end else if ({1'b0, pb_idx} == pb_end1) begin
            pb_word = sap_mask(pb_shift, pb_wl);
            pb_we   = (pb_dsp || pb_left) ? 2'b01 : 2'b10;
        end else if (pb_dsp && {1'b0, pb_idx} == pb_end2) begin
            pb_word = sap_mask(pb_shift, pb_wl);
            pb_we   = 2'b10;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pb_prev_q <= 1'b0;
            pb_cnt_q  <= 8'hFF;
            pb_col_q  <= 32'h0000_0000;
        end else if (pb_ev.take) begin
            pb_prev_q <= pb_lrc;
            pb_cnt_q  <= pb_idx;
            pb_col_q  <= pb_shift;
        end
    end

    // Received words and per-channel zero run counters
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int c = 0; c < 2; c++) begin
                pb_word_q[c] <= 32'h0000_0000;
                zc_q[c]      <= 11'h000;
            end
        end else if (pb_ev.take) begin
            for (int c = 0; c < 2; c++) begin
                if (pb_we[c]) begin
                    pb_word_q[c] <= pb_word;
                    if (pb_word != 32'h0000_0000) begin
                        zc_q[c] <= 11'h000;
                    end else if (zc_q[c] != ZERO_RUN) begin
                        zc_q[c] <= zc_q[c] + 11'h001;
                    end
                end
            end
        end
    end

    assign zero_l              = (zc_q[0] == ZERO_RUN);
    assign zero_r              = (zc_q[1] == ZERO_RUN);
    assign zero_detect_mute    = zero_l & zero_r;
    assign playback_mute_left  = zero_l & ctrl_q[SAP_CTRL_ZMUTE_EN];
    assign playback_mute_right = zero_r & ctrl_q[SAP_CTRL_ZMUTE_EN];

    // Record sender, evaluated at each launching edge
    logic        rc_lrc, rc_start, rc_trans, rc_left, rc_dsp, rc_bit;
    logic [7:0]  rc_idx;
    logic [8:0]  rc_off, rc_pos, rc_wl9;

    always_comb begin
        rc_lrc   = rc_ev.frame;
        rc_dsp   = (rc_fmt == SAP_FMT_DSP);
        rc_trans = rc_lrc ^ rc_prev_q;
        rc_start = rc_dsp ? (rc_lrc & ~rc_prev_q) : rc_trans;
        rc_idx   = rc_start ? 8'h00 : ((rc_cnt_q == 8'hFF) ? rc_cnt_q : rc_cnt_q + 8'h01);
        rc_wl9   = {3'b000, rc_wl};
        case (rc_fmt)
            SAP_FMT_LJ:  rc_off = 9'h000;
            SAP_FMT_I2S: rc_off = 9'h001;
            SAP_FMT_DSP: rc_off = rc_pol ? 9'h000 : 9'h001;
            // Right justified ends the word on the fall before the next frame edge
            default:     rc_off = (rc_len_q > rc_wl9) ? rc_len_q - rc_wl9 : 9'h000;
        endcase
        rc_pos  = {1'b0, rc_idx} - rc_off;
        rc_left = (rc_lrc ^ rc_pol) ^ (rc_fmt == SAP_FMT_I2S);
        rc_bit  = 1'b0;
        if ({1'b0, rc_idx} >= rc_off) begin
            if (rc_pos < rc_wl9) begin
                rc_bit = sap_bit((rc_dsp || rc_left) ? rec_word_q[0] : rec_word_q[1],
                                 rc_wl9 - 9'h001 - rc_pos);
            end else if (rc_dsp && rc_pos < (rc_wl9 << 1)) begin
                rc_bit = sap_bit(rec_word_q[1], (rc_wl9 << 1) - 9'h001 - rc_pos);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rc_prev_q <= 1'b0;
            rc_cnt_q  <= 8'hFF;
            rc_len_q  <= {1'b0, FRAME_HALF_BITS};
            rc_out_q  <= 1'b0;
        end else if (rc_ev.launch) begin
            rc_prev_q <= rc_lrc;
            rc_cnt_q  <= rc_idx;
            rc_out_q  <= rc_bit;
            if (rc_trans && !rc_dsp) begin
                rc_len_q <= {1'b0, rc_cnt_q} + 9'h001;
            end
        end
    end

    assign record_serial_out = rc_out_q;

    // Avalon slave: one wait state, reads and writes complete on the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                SAP_OFS_CTRL:      rdata_q <= ctrl_q;
                SAP_OFS_STATUS:    rdata_q <= {28'h000_0000, deemph_enable, hw, zero_r, zero_l};
                SAP_OFS_PB_LEFT:   rdata_q <= pb_word_q[0];
                SAP_OFS_PB_RIGHT:  rdata_q <= pb_word_q[1];
                SAP_OFS_REC_LEFT:  rdata_q <= rec_word_q[0];
                SAP_OFS_REC_RIGHT: rdata_q <= rec_word_q[1];
                default:           rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q        <= SAP_CTRL_RESET;
            rec_word_q[0] <= 32'h0000_0000;
            rec_word_q[1] <= 32'h0000_0000;
        end else if (avs_write && ack_q) begin
            case (avs_address)
                SAP_OFS_CTRL:      ctrl_q        <= avs_writedata & SAP_CTRL_MASK;
                SAP_OFS_REC_LEFT:  rec_word_q[0] <= avs_writedata;
                SAP_OFS_REC_RIGHT: rec_word_q[1] <= avs_writedata;
                default:           ctrl_q        <= ctrl_q;
            endcase
        end
    end
endmodule // sap_audio_port
`default_nettype wire

//--- testbench/sap_audio_port_props.sv
// Pin-level checks for the serial audio port
`timescale 1ns/1ps
`default_nettype none
module sap_audio_port_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic hw_mode_pin,
    input wire logic deemph_select_pin,
    input wire logic deemph_enable,
    input wire logic playback_bit_clock_o,
    input wire logic playback_bit_clock_oe,
    input wire logic playback_frame_clock_oe,
    input wire logic record_bit_clock_i,
    input wire logic record_bit_clock_oe,
    input wire logic record_frame_clock_oe,
    input wire logic record_serial_out
);
    logic       rb_q;
    logic [3:0] fall_age_q;
    wire logic  any_oe = playback_bit_clock_oe | playback_frame_clock_oe
                       | record_bit_clock_oe | record_frame_clock_oe;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Saturates so a change long after a fall is still flagged
    always_ff @(posedge clock) begin
        rb_q <= record_bit_clock_i;
        if (rst) begin
            fall_age_q <= 4'hF;
        end else if (rb_q && !record_bit_clock_i) begin
            fall_age_q <= 4'h0;
        end else if (fall_age_q != 4'hF) begin
            fall_age_q <= fall_age_q + 4'h1;
        end
    end
    a_req_waits: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state");
    a_wait_single: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    a_reset_slave: assert property (disable iff (1'b0) rst |=> !any_oe)
        else $error("clock driven after reset");
    a_hw_slave: assert property (hw_mode_pin [*5] |-> !any_oe)
        else $error("clock driven in hardware mode");
    a_oe_paired: assert property (playback_bit_clock_oe == playback_frame_clock_oe
        && record_bit_clock_oe == record_frame_clock_oe) else $error("clock pair split");
    a_hw_deemph: assert property ((hw_mode_pin && $stable(deemph_select_pin)) [*5]
        |-> deemph_enable == deemph_select_pin) else $error("de-emphasis mismatch");
    a_launch_fall: assert property (hw_mode_pin && $changed(record_serial_out)
        |-> fall_age_q <= 4'h6) else $error("record data off its edge");
    a_master_half: assert property (playback_bit_clock_oe && $rose(playback_bit_clock_o)
        |=> $stable(playback_bit_clock_o) [*7]) else $error("bit clock half too short");
    c_hw_mode: cover property (hw_mode_pin [*5] ##0 !any_oe);
    c_master: cover property (playback_bit_clock_oe && $rose(playback_bit_clock_o));
    c_launch: cover property (hw_mode_pin && $changed(record_serial_out));
endmodule // sap_audio_port_props
`default_nettype wire

//--- testbench/sap_ctl_model.sv
// Controller-side serial port model
`timescale 1ns/1ps
`default_nettype none
module sap_ctl_model (
    output logic      bclk,
    output logic      frm,
    output logic      sd,
    input  wire logic si
);
    logic [31:0] cl, cr;
    initial {bclk, frm, sd} = 3'b000;
    // f: 0 right, 1 left justified, 2 I2S, 3 DSP A, 4 DSP B
    task automatic run(input int f, input int wl, input logic inv, input logic [31:0] l,
                       input logic [31:0] r, input int nfr);
        int   n, p, q;
        logic rc, ok;
        n  = (f > 2) ? 192 : 64;
        cl = 32'h0000_0000;
        cr = 32'h0000_0000;
        repeat (nfr) begin
            for (int i = 0; i < n; i++) begin
                if (f > 2) begin
                    q   = i - int'(f == 3);
                    rc  = (q >= wl);
                    p   = rc ? q - wl : q;
                    ok  = (q >= 0) && (q < 2 * wl);
                    frm = (i == 0);
                end else begin
                    rc  = (i >= 32);
                    p   = (f == 0) ? i % 32 - (32 - wl) : i % 32 - int'(f == 2);
                    ok  = (p >= 0) && (p < wl);
                    frm = !rc ^ (f == 2);
                end
                // Data moves opposite the sampling edge
                bclk = inv;
                sd   = ok ? (rc ? r[wl-1-p] : l[wl-1-p]) : ~sd;
                #32;
                bclk = !inv;
                if (ok) begin
                    if (rc) cr[wl-1-p] = si;
                    else cl[wl-1-p] = si;
                end
                #32;
            end
        end
        sd = ~sd;
    endtask
endmodule // sap_ctl_model
`default_nettype wire

//--- testbench/sap_audio_port_test.sv
// Bench for the serial audio port
`timescale 1ns/1ps
`default_nettype none
module sap_audio_port_test
    import sap_pkg::*;
;
    logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        hw_mode_pin = 1'b0, format_select_pin = 1'b0, wordlen_select_pin = 1'b0;
    logic        deemph_select_pin = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic        avs_waitrequest, deemph_enable, zero_detect_mute, playback_mute_left;
    logic        playback_mute_right, record_serial_out, playback_bit_clock_o;
    logic        playback_bit_clock_oe, playback_frame_clock_o, playback_frame_clock_oe;
    logic        record_bit_clock_o, record_bit_clock_oe, record_frame_clock_o;
    logic        record_frame_clock_oe;
    wire logic   playback_serial_in, m_pbc, m_pbf, m_rc, m_rf;
    wire logic   playback_bit_clock_i = playback_bit_clock_oe ? playback_bit_clock_o : m_pbc;
    wire logic   playback_frame_clock_i = playback_frame_clock_oe ? playback_frame_clock_o : m_pbf;
    wire logic   record_bit_clock_i = record_bit_clock_oe ? record_bit_clock_o : m_rc;
    wire logic   record_frame_clock_i = record_frame_clock_oe ? record_frame_clock_o : m_rf;
    wire logic [3:0] oe_all = {playback_bit_clock_oe, playback_frame_clock_oe,
                               record_bit_clock_oe, record_frame_clock_oe};
    int          error_cnt = 0, checked = 0, cyc = 0;

    always #2.5 clock = ~clock;
    sap_audio_port i_dut (.*);
    sap_ctl_model i_pb (.bclk(m_pbc), .frm(m_pbf), .sd(playback_serial_in), .si(1'b0));
    sap_ctl_model i_rec (.bclk(m_rc), .frm(m_rf), .sd(), .si(record_serial_out));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic link(input int f, input int wl, input logic inv);
        logic [31:0] l, r, m;
        int          wc;
        l  = 32'h5A3C_96E1 ^ 32'(f * wl);
        r  = 32'hC3A5_0F69 + 32'(wl);
        m  = 32'hFFFF_FFFF >> (32 - wl);
        wc = (wl == 32) ? 3 : (wl - 16) / 4;
        bus(1'b1, SAP_OFS_CTRL, 32'(((f > 2) ? 3 : f) * 1040 + wc * 8448
            + int'(f == 4) * 4160 + int'(inv) * 12));
        bus(1'b1, SAP_OFS_REC_LEFT, ~l);
        bus(1'b1, SAP_OFS_REC_RIGHT, ~r);
        fork
            i_pb.run(f, wl, inv, l, r, 3);
            #13 i_rec.run(f, wl, inv, l, r, 3);
        join
        repeat (8) @(posedge clock);
        bus(1'b0, SAP_OFS_PB_LEFT, 32'h0000_0000);
        check(q, l & m);
        bus(1'b0, SAP_OFS_PB_RIGHT, 32'h0000_0000);
        check(q, r & m);
        check(i_rec.cl, ~l & m);
        check(i_rec.cr, ~r & m);
        check(32'({zero_detect_mute, playback_mute_left, playback_mute_right}),
              32'h0000_0000);
        $display("link %0d/%0d done", f, wl);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        bus(1'b0, SAP_OFS_CTRL, 32'h0000_0000);
        check(q, SAP_CTRL_RESET);
        bus(1'b1, SAP_OFS_CTRL, 32'hFFFF_FFFC);
        bus(1'b0, SAP_OFS_CTRL, 32'h0000_0000);
        check(q, SAP_CTRL_MASK & 32'hFFFF_FFFC);
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus(1'b0, 5'h18, 32'h0000_0000);
        check(q, 32'h0000_0000);
        bus(1'b1, SAP_OFS_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, SAP_OFS_STATUS, 32'h0000_0000);
        check(q, 32'h0000_0008);
        $display("register test done");
        link(1, 32, 1'b1);
        link(0, 20, 1'b0);
        link(2, 16, 1'b0);
        link(3, 24, 1'b0);
        link(4, 20, 1'b0);
        bus(1'b1, SAP_OFS_CTRL, 32'h0000_0003);
        repeat (48) @(posedge clock);
        check(32'(oe_all), 32'h0000_000F);
        hw_mode_pin       <= 1'b1;
        deemph_select_pin <= 1'b1;
        repeat (8) @(posedge clock);
        check(32'(oe_all), 32'h0000_0000);
        check(32'(deemph_enable), 32'h0000_0001);
        $display("mode test done");
        for (int k = 0; k < 4; k++) begin
            format_select_pin  <= k[1];
            wordlen_select_pin <= k[0];
            repeat (4) @(posedge clock);
            link(k[1] ? 2 : 0, (k == 2) ? 16 : ((k == 1) ? 20 : 24), 1'b0);
        end
        test_done();
    end
endmodule // sap_audio_port_test

bind sap_audio_port sap_audio_port_props i_props (.*);
`default_nettype wire
